// file: core/serial_baud_and_sync_slave_tx.sv
// Baud divider and synchronous slave transmitter with plain register port.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module serial_baud_and_sync_slave_tx #(
  parameter int DIV_W = 16
) (
  // Clock and reset.
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  // Register port.
  input  wire sbs_pkg::reg_req_t req_i,
  output logic [7:0]            rdata_o,
  // Serial pins: clock pin as input, output and enable; data pin as output and enable.
  input  wire logic             clk_pin_i,
  output logic                  clk_pin_o,
  output logic                  clk_pin_oe_o,
  output logic                  data_pin_o,
  output logic                  data_pin_oe_o,
  // Baud tick, wake request and interrupt request.
  output logic                  baud_tick_o,
  output logic                  wake_o,
  output logic                  irq_o
);
  initial begin
    if (DIV_W != 16) $error("DIV_W must be 16");
  end
  // Register state.
  logic [7:0] baud_control_reg;
  logic [7:0] rx_status_reg;
  logic [7:0] tx_status_reg;
  logic [7:0] divisor_low_reg;
  logic [7:0] divisor_high_reg;
  logic [7:0] holding_reg;
  logic       holding_full_reg;
  logic       ninth_hold_reg;
  logic       tx_flag_reg;
  logic [3:0] irq_en_reg;
  logic [8:0] shift_reg;
  logic [3:0] bits_left_reg;
  logic [21:0] baud_cnt_reg;
  logic [2:0] pin_sync_reg;
  logic       pin_state_reg;
  sbs_pkg::tx_state_t state_reg;
  logic       wr_div;
  logic       sync_mode;
  logic       slave_tx;
  logic       wide;
  logic [2:0] mult_sh;
  logic [21:0] period;
  logic       fall;
  logic       load;
  logic       shift_done;
  logic [15:0] div_val;

  // Mode decode; the slave transmits only with both receive enables clear.
  assign sync_mode = tx_status_reg[sbs_pkg::TC_SYNC];
  assign wide      = baud_control_reg[sbs_pkg::BC_WIDE_DIV];
  assign slave_tx  = sync_mode & ~tx_status_reg[sbs_pkg::TC_CLK_MASTER]
                   & rx_status_reg[sbs_pkg::RC_PORT_EN]
                   & ~rx_status_reg[sbs_pkg::RC_SINGLE_RX]
                   & ~rx_status_reg[sbs_pkg::RC_CONT_RX]
                   & tx_status_reg[sbs_pkg::TC_TX_EN];
  assign wr_div = req_i.wr & ((req_i.addr == sbs_pkg::ADDR_DIVISOR_LOW)
                | (req_i.addr == sbs_pkg::ADDR_DIVISOR_HIGH));
  // Narrow mode uses only the low byte of the divisor.
  assign div_val = wide ? {divisor_high_reg, divisor_low_reg} : {8'h00, divisor_low_reg};

  // Multiplier choice; synchronous mode ignores the high-speed bit.
  always_comb begin
    if (sync_mode) begin
      mult_sh = sbs_pkg::MULT_4;
    end else if (!wide) begin
      mult_sh = tx_status_reg[sbs_pkg::TC_HIGH_SPEED] ? sbs_pkg::MULT_16
                                                       : sbs_pkg::MULT_64;
    end else begin
      mult_sh = tx_status_reg[sbs_pkg::TC_HIGH_SPEED] ? sbs_pkg::MULT_4
                                                       : sbs_pkg::MULT_16;
    end
  end
  // Period in clocks is multiplier times divisor plus one.
  assign period = ({6'h00, div_val} + 22'h000001) << mult_sh;

  // Free-running baud timer; a divisor write restarts it so a new rate lands at once.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_cnt_reg <= 22'h000000;
      baud_tick_o  <= 1'b0;
    end else if (wr_div) begin
      baud_cnt_reg <= 22'h000000;
      baud_tick_o  <= 1'b0;
    end else if (baud_cnt_reg >= period - 22'h000001) begin
      baud_cnt_reg <= 22'h000000;
      baud_tick_o  <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 22'h000001;
      baud_tick_o  <= 1'b0;
    end
  end

  // Clock pin synchroniser; stage two and three must agree before a change counts.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_sync_reg  <= 3'h0;
      pin_state_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], clk_pin_i};
      if (pin_sync_reg[2] == pin_sync_reg[1]) begin
        pin_state_reg <= pin_sync_reg[2];
      end
    end
  end
  // Data changes on the falling external edge, or the rising one with inverted polarity.
  assign fall = slave_tx & (pin_sync_reg[2] == pin_sync_reg[1])
              & (pin_sync_reg[2] != pin_state_reg)
              & (pin_sync_reg[2] == baud_control_reg[sbs_pkg::BC_CLK_POL]);
  assign shift_done = (state_reg == sbs_pkg::TX_SHIFT) & fall & (bits_left_reg == 4'h1);
  // A held word enters the shifter when the shifter is empty, sleep or not.
  assign load = slave_tx & holding_full_reg
              & ((state_reg == sbs_pkg::TX_IDLE) | shift_done);

  // Shift path: the first bit is presented as the word is loaded, LSB first.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg     <= sbs_pkg::TX_IDLE;
      shift_reg     <= 9'h000;
      bits_left_reg <= 4'h0;
    end else if (!slave_tx) begin
      state_reg     <= sbs_pkg::TX_IDLE;
      bits_left_reg <= 4'h0;
    end else if (load) begin
      state_reg     <= sbs_pkg::TX_SHIFT;
      shift_reg     <= {ninth_hold_reg, holding_reg};
      bits_left_reg <= tx_status_reg[sbs_pkg::TC_NINE_BIT] ? 4'h9 : 4'h8;
    end else begin
      case (state_reg)
        sbs_pkg::TX_SHIFT: begin
          if (fall) begin
            shift_reg     <= {1'b0, shift_reg[8:1]};
            bits_left_reg <= bits_left_reg - 4'h1;
            if (bits_left_reg == 4'h1) begin
              state_reg <= sbs_pkg::TX_IDLE;
            end
          end
        end
        default: state_reg <= sbs_pkg::TX_IDLE;
      endcase
    end
  end

  // Holding register; a write fills it and starts transmission.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      holding_reg      <= 8'h00;
      ninth_hold_reg   <= 1'b0;
      holding_full_reg <= 1'b0;
    end else if (req_i.wr && req_i.addr == sbs_pkg::ADDR_TX_HOLDING) begin
      holding_reg      <= req_i.wdata;
      ninth_hold_reg   <= tx_status_reg[sbs_pkg::TC_NINTH_BIT];
      holding_full_reg <= 1'b1;
    end else if (load) begin
      holding_full_reg <= 1'b0;
    end
  end

  // Transmit flag tracks an empty holding register; it rises only as a word leaves it.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_flag_reg <= 1'b1;
    end else if (req_i.wr && req_i.addr == sbs_pkg::ADDR_TX_HOLDING) begin
      tx_flag_reg <= 1'b0;
    end else if (load) begin
      tx_flag_reg <= 1'b1;
    end
  end

  // Control register writes; hardware status bits are not writable.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_control_reg <= sbs_pkg::RST_BAUD_CONTROL;
      rx_status_reg    <= sbs_pkg::RST_RX_STATUS;
      tx_status_reg    <= sbs_pkg::RST_TX_STATUS;
      divisor_low_reg  <= sbs_pkg::RST_DIVISOR;
      divisor_high_reg <= sbs_pkg::RST_DIVISOR;
      irq_en_reg       <= 4'h0;
    end else if (req_i.wr) begin
      case (req_i.addr)
        sbs_pkg::ADDR_BAUD_CONTROL:  baud_control_reg <= {2'b01, 1'b0, req_i.wdata[4:3], 3'h0};
        sbs_pkg::ADDR_RX_STATUS_CTL: rx_status_reg    <= req_i.wdata;
        sbs_pkg::ADDR_DIVISOR_LOW:   divisor_low_reg  <= req_i.wdata;
        sbs_pkg::ADDR_DIVISOR_HIGH:  divisor_high_reg <= req_i.wdata;
        sbs_pkg::ADDR_TX_STATUS_CTL: tx_status_reg    <= {req_i.wdata[7:2], 1'b0,
                                                          req_i.wdata[0]};
        sbs_pkg::ADDR_IRQ_CONTROL:   irq_en_reg       <= req_i.wdata[4:1];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped and write-only addresses read zero.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      case (req_i.addr)
        sbs_pkg::ADDR_BAUD_CONTROL:  rdata_o <= baud_control_reg;
        sbs_pkg::ADDR_RX_STATUS_CTL: rdata_o <= rx_status_reg;
        sbs_pkg::ADDR_DIVISOR_LOW:   rdata_o <= divisor_low_reg;
        sbs_pkg::ADDR_DIVISOR_HIGH:  rdata_o <= divisor_high_reg;
        sbs_pkg::ADDR_TX_STATUS_CTL: rdata_o <= {tx_status_reg[7:2],
                                                 state_reg == sbs_pkg::TX_IDLE,
                                                 tx_status_reg[0]};
        sbs_pkg::ADDR_IRQ_CONTROL:   rdata_o <= {3'h0, irq_en_reg, tx_flag_reg};
        default:                     rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Pins: the clock pin is never driven by a slave; data drives only while transmitting.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_pin_o     <= 1'b0;
      clk_pin_oe_o  <= 1'b0;
      data_pin_o    <= 1'b1;
      data_pin_oe_o <= 1'b0;
    end else begin
      clk_pin_o     <= 1'b0;
      clk_pin_oe_o  <= 1'b0;
      data_pin_o    <= load ? (holding_full_reg ? holding_reg[0] : 1'b1)
                            : (fall ? shift_reg[1] : data_pin_o);
      data_pin_oe_o <= slave_tx;
    end
  end

  // Wake needs peripheral and transmit enables; service entry also needs the global enable.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o <= 1'b0;
      irq_o  <= 1'b0;
    end else begin
      wake_o <= irq_en_reg[3] & tx_flag_reg & irq_en_reg[0] & irq_en_reg[1];
      irq_o  <= tx_flag_reg & irq_en_reg[0] & irq_en_reg[1] & irq_en_reg[2];
    end
  end
endmodule
`default_nettype wire

// file: shared/sbs_pkg.sv
// Package of register offsets, field positions, reset values and types for the serial baud block.
// Operation
// - Divider is 8-bit after reset, 16-bit when wide select set.
// - Divisor pair sets period of one free-running baud timer for all modes.
// - Asynchronous period multiplier depends on high-speed and wide select together.
// - Synchronous mode ignores high-speed select.
// - Async, 8-bit, low speed: rate is clock over 64 times divisor plus one.
// - Async, 8-bit, high speed: rate is clock over 16 times divisor plus one.
// - Synchronous, any width: rate is clock over 4 times divisor plus one.
// - Writing either divisor register clears the baud timer at once.
// - Slave transmits when both receive enables clear, else receives; this block has no receive path and only releases the data pin.
// - Slave transmit behaves as master transmit except in sleep.
// - Entering sleep with two words queued, first moves to shifter and shifts.
// - Second word stays held and transmit flag stays clear meanwhile.
// - After first word shifts out, second moves on and flag sets.
// - Flag with enables wakes from sleep; with global enable, enters service.
// - Writing the holding register starts transmission.
package sbs_pkg;
  // Register addresses, chosen freely since none are printed.
  localparam logic [3:0] ADDR_BAUD_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_RX_STATUS_CTL = 4'h1;
  localparam logic [3:0] ADDR_DIVISOR_LOW   = 4'h2;
  localparam logic [3:0] ADDR_DIVISOR_HIGH  = 4'h3;
  localparam logic [3:0] ADDR_TX_STATUS_CTL = 4'h4;
  localparam logic [3:0] ADDR_RECEIVE_DATA  = 4'h5;
  localparam logic [3:0] ADDR_TX_HOLDING    = 4'h6;
  localparam logic [3:0] ADDR_IRQ_CONTROL   = 4'h7;
  // Baud control fields.
  localparam int BC_RX_IDLE  = 6;
  localparam int BC_CLK_POL  = 4;
  localparam int BC_WIDE_DIV = 3;
  // Receive status and control fields.
  localparam int RC_PORT_EN   = 7;
  localparam int RC_SINGLE_RX = 5;
  localparam int RC_CONT_RX   = 4;
  // Transmit status and control fields.
  localparam int TC_CLK_MASTER = 7;
  localparam int TC_NINE_BIT   = 6;
  localparam int TC_TX_EN      = 5;
  localparam int TC_SYNC       = 4;
  localparam int TC_HIGH_SPEED = 2;
  localparam int TC_SHIFT_IDLE = 1;
  localparam int TC_NINTH_BIT  = 0;
  // Interrupt control fields: flag, enables, sleep.
  localparam int IC_TX_FLAG  = 0;
  localparam int IC_TX_IE    = 1;
  localparam int IC_PERIPH_IE = 2;
  localparam int IC_GLOBAL_IE = 3;
  localparam int IC_SLEEP    = 4;
  // Reset values.
  localparam logic [7:0] RST_BAUD_CONTROL = 8'h40;
  localparam logic [7:0] RST_RX_STATUS    = 8'h00;
  localparam logic [7:0] RST_TX_STATUS    = 8'h02;
  localparam logic [7:0] RST_DIVISOR      = 8'h00;
  // Baud multipliers as shifts of the divisor period count.
  localparam logic [2:0] MULT_64 = 3'h6;
  localparam logic [2:0] MULT_16 = 3'h4;
  localparam logic [2:0] MULT_4  = 3'h2;
  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  // Transmit path states.
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;
endpackage

// file: verification/sbs_chk.sv
// Port checker for the baud divider and slave transmitter.
`timescale 1ns/1ps
`default_nettype none
module sbs_chk (
  // Clock, reset and register port.
  input wire logic              core_clk_i,
  input wire logic              rstn_i,
  input wire sbs_pkg::reg_req_t req_i,
  input wire logic [7:0]        rdata_o,
  // Pins and status outputs.
  input wire logic              clk_pin_i,
  input wire logic              clk_pin_o,
  input wire logic              clk_pin_oe_o,
  input wire logic              data_pin_o,
  input wire logic              data_pin_oe_o,
  input wire logic              baud_tick_o,
  input wire logic              wake_o,
  input wire logic              irq_o
);
  logic [3:0] quiet_reg;
  logic       pin_reg;
  // Cycles since a pin change or write; it saturates so a long idle never wraps.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quiet_reg <= 4'h0;
      pin_reg   <= 1'b1;
    end else begin
      pin_reg <= clk_pin_i;
      if (req_i.wr || (clk_pin_i != pin_reg)) quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_clk_pin_released: assert property (!clk_pin_oe_o && !clk_pin_o)
    else $error("slave drives the clock pin");
  a_rdata_idle_zero: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside the answer cycle");
  a_unmapped_reads_zero: assert property (req_i.rd && (req_i.addr[3] ||
    req_i.addr == 4'h5) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_irq_enables_off: assert property (req_i.wr && req_i.addr == 4'h7 &&
    req_i.wdata[2:1] == 2'b00 |-> ##3 !irq_o && !wake_o)
    else $error("interrupt or wake without enables");
  a_tick_min_gap: assert property (baud_tick_o |=> !baud_tick_o [*3])
    else $error("baud ticks closer than four cycles");
  a_divisor_write_clears: assert property (req_i.wr && (req_i.addr == 4'h2 ||
    req_i.addr == 4'h3) |-> ##2 !baud_tick_o [*3])
    else $error("tick right after divisor write");
  a_data_has_cause: assert property (data_pin_oe_o && $past(data_pin_oe_o) &&
    $changed(data_pin_o) |-> quiet_reg < 4'h8)
    else $error("data changed without clock edge or write");
  a_mode_by_write: assert property ($changed(data_pin_oe_o) |->
    $past(req_i.wr) || $past(req_i.wr, 2))
    else $error("transmit mode changed without a write");
endmodule
bind serial_baud_and_sync_slave_tx sbs_chk i_sbs_chk (.core_clk_i, .rstn_i, .req_i,
  .rdata_o, .clk_pin_i, .clk_pin_o, .clk_pin_oe_o, .data_pin_o, .data_pin_oe_o,
  .baud_tick_o, .wake_o, .irq_o);
`default_nettype wire

// file: verification/sbs_sync_master.sv
// Behavioural external master that clocks words out of the slave.
`timescale 1ns/1ps
`default_nettype none
module sbs_sync_master #(
  parameter int HALF = 8
) (
  // Core clock times the serial clock phases.
  input  wire logic       core_clk_i,
  // Start request and data line from the slave.
  input  wire logic       go_i,
  input  wire logic       data_i,
  input  wire logic       oe_i,
  // Serial clock, captured word and activity flag.
  output logic            clk_o,
  output logic [7:0]      word_o,
  output logic            busy_o
);
  initial begin
    clk_o = 1'b1;
    word_o = 8'h00;
    busy_o = 1'b0;
  end
  // Idle high, falling edges active; each bit is taken just before the edge
  // that moves the slave on, and the clock stands still between frames.
  always @(posedge core_clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        // A released line reads as the inverse of the same bit captured in the previous frame.
        word_o[i] <= oe_i ? data_i : ~word_o[i];
        clk_o <= 1'b0;
        repeat (HALF) @(posedge core_clk_i);
        clk_o <= 1'b1;
        repeat (HALF) @(posedge core_clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verification/serial_baud_and_sync_slave_tx_bench.sv
// Self-checking bench for the baud divider and slave transmitter.
`timescale 1ns/1ps
`default_nettype none
module serial_baud_and_sync_slave_tx_bench;
  logic              core_clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  sbs_pkg::reg_req_t req_i = '0;
  logic [7:0]        rdata_o, word;
  logic              clk_pin_i, clk_pin_o, clk_pin_oe_o, data_pin_o, data_pin_oe_o;
  logic              baud_tick_o, wake_o, irq_o, busy;
  logic              go = 1'b0;
  int                err_total = 0;
  int                total_checks = 0;
  int                n, m;
  // A 10 ns half period gives the 50 MHz core clock.
  always #10 core_clk_i = ~core_clk_i;
  serial_baud_and_sync_slave_tx i_serial_baud_and_sync_slave_tx (.core_clk_i, .rstn_i,
    .req_i, .rdata_o, .clk_pin_i, .clk_pin_o, .clk_pin_oe_o, .data_pin_o,
    .data_pin_oe_o, .baud_tick_o, .wake_o, .irq_o);
  sbs_sync_master i_sbs_sync_master (.core_clk_i, .go_i(go), .data_i(data_pin_o),
    .oe_i(data_pin_oe_o), .clk_o(clk_pin_i), .word_o(word), .busy_o(busy));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req_i.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req_i.rd <= 1'b0;
    #1 check(rdata_o, e);
  endtask
  // Set a mode, write the divisor and time the first two ticks after it.
  task automatic period(input logic [7:0] tx, input logic [7:0] bc, input int per);
    wr(4'h4, tx);
    wr(4'h0, bc);
    wr(4'h2, 8'h02);
    n = 0;
    do begin @(posedge core_clk_i); #1 n++; end while (baud_tick_o !== 1'b1 && n < 9000);
    m = 0;
    do begin @(posedge core_clk_i); #1 m++; end while (baud_tick_o !== 1'b1 && m < 9000);
    check(16'(n >= per - 1 && n <= per + 2), 16'h1);
    check(16'(m), 16'(per));
  endtask
  task automatic frame(input logic [7:0] e);
    @(posedge core_clk_i);
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    n = 0;
    do begin @(posedge core_clk_i); #1 n++; end while (busy && n < 1000);
    check(word, e);
  endtask
  // Waits are bounded, so a hang only ends here when the design never ticks.
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(4'h0, 8'h40);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h4, 8'h02);
    rd(4'h7, 8'h01);
    rd(4'h9, 8'h00);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h02);
    wr(4'h3, 8'h01);
    rd(4'h3, 8'h01);
    period(8'h00, 8'h00, 192);
    period(8'h04, 8'h00, 48);
    period(8'h00, 8'h08, 4144);
    period(8'h04, 8'h08, 1036);
    period(8'h14, 8'h00, 12);
    period(8'h10, 8'h08, 1036);
    // The pins are digital-only here, so no analog select needs clearing first.
    wr(4'h1, 8'h80);
    wr(4'h4, 8'h30);
    wr(4'h0, 8'h00);
    wr(4'h6, 8'ha5);
    wr(4'h6, 8'h3c);
    wr(4'h7, 8'h16);
    rd(4'h7, 8'h16);
    check({clk_pin_oe_o, data_pin_oe_o, wake_o}, 16'h2);
    frame(8'ha5);
    check({wake_o, irq_o}, 16'h2);
    rd(4'h7, 8'h17);
    wr(4'h7, 8'h1e);
    repeat (3) @(posedge core_clk_i);
    #1 check(irq_o, 16'h1);
    frame(8'h3c);
    // Nine-bit word: ninth bit set before the low byte; eight edges leave it on the line.
    wr(4'h4, 8'h71);
    wr(4'h6, 8'h5a);
    frame(8'h5a);
    check(data_pin_o, 16'h1);
    rd(4'h4, 8'h71);
    wr(4'h1, 8'ha0);
    repeat (3) @(posedge core_clk_i);
    #1 check(data_pin_oe_o, 16'h0);
    wr(4'h7, 8'h00);
    repeat (4) @(posedge core_clk_i);
    #1 check({wake_o, irq_o}, 16'h0);
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
